// file: rtl/ssp_pkg.sv
// Purpose: Shared constants for the serial register port.
// Assumes: CLK at 250 MHz; byte-wide register map of 256 entries.
// Notes:   Timing counts derive from times in ns and the clock period.
package ssp_pkg;

  localparam int CLK_PERIOD_NS = 4;

  // Interface detection window after reset
  localparam int DETECT_TIME_NS = 1000000;
  localparam int DETECT_CYCLES  = DETECT_TIME_NS / CLK_PERIOD_NS;
  localparam int DETECT_CNT_W   = 20;

  // Low phase of the reset-complete pulse, inside the 500 ns window
  localparam int INT_WINDOW_NS  = 500;
  localparam int INT_LOW_NS     = 250;
  localparam int INT_LOW_CYCLES = INT_LOW_NS / CLK_PERIOD_NS;
  localparam int INT_CNT_W      = 8;

  // Register map geometry
  localparam int REG_AW    = 8;
  localparam int REG_DW    = 8;
  localparam int REG_DEPTH = 256;

  // Control register holding the active bit
  localparam logic [7:0] CTRL_ADDR  = 8'h2A;
  localparam int         ACTIVE_BIT = 0;

  // Registers reloaded on a standby-to-active transition
  localparam int REINIT_N = 4;
  localparam int REINIT_W = 2;
  localparam logic [7:0] REINIT_ADDR [REINIT_N] = '{8'h00, 8'h0C, 8'h16, 8'h1E};
  localparam logic [7:0] REINIT_VAL  [REINIT_N] = '{8'h00, 8'h00, 8'h00, 8'h00};

  // Synchroniser lane order in the CLK domain
  localparam int SYNC_W     = 5;
  localparam int LANE_CS    = 0;
  localparam int LANE_WR    = 1;
  localparam int LANE_RD    = 2;
  localparam int LANE_SA_HI = 3;
  localparam int LANE_SA_LO = 4;
  localparam logic [4:0] SYNC_RESET = 5'h01;

  typedef enum logic [1:0] {
    ST_DETECT,
    ST_INT_LOW,
    ST_RUN
  } ssp_state_t;

endpackage : ssp_pkg

// file: rtl/ssp_sync.sv
// Purpose: Two-flop synchroniser for a group of independent levels.
// Assumes: Each bit is a level or a toggle; no bus values pass here.
// Notes:   Only the second flop is visible outside.
module ssp_sync #(
  parameter int         WIDTH     = 1,
  parameter logic [4:0] RESET_VAL = 5'h00
) (
  input  wire logic             clk,
  input  wire logic             srst,
  input  wire logic [WIDTH-1:0] async_in,
  output      logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage1;

  always_ff @(posedge clk) begin
    if (srst) begin
      stage1   <= RESET_VAL[WIDTH-1:0];
      sync_out <= RESET_VAL[WIDTH-1:0];
    end else begin
      stage1   <= async_in;
      sync_out <= stage1;
    end
  end
endmodule : ssp_sync

// file: rtl/ssp_regmem.sv
// Purpose: Byte-wide register map storage, one port.
// Assumes: Single clock; write and read share the address.
// Notes:   Read data comes out of a register one cycle after the address.
module ssp_regmem
  import ssp_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              we,
  input  wire logic [REG_AW-1:0] addr,
  input  wire logic [REG_DW-1:0] wdata,
  output      logic [REG_DW-1:0] rdata
);
  logic [REG_DW-1:0] mem [REG_DEPTH];

  always_ff @(posedge clk) begin
    if (we) begin
      mem[addr] <= wdata;
    end
    rdata <= mem[addr];
  end
endmodule : ssp_regmem

// file: rtl/ssp_top.sv
// Purpose: SPI slave port to a byte-wide register map, with interface
//          detection, reset-complete pulse and standby/active control.
// Assumes: SCLK idles low and stops outside frames; CS_N frames transfers.
// Notes:   Serial logic runs on SCLK; storage and control run on CLK.

// Behaviour
// - Port is a slave only; every transfer begins with the master.
// - First bit one means write; incoming data bytes are stored.
// - First bit zero means read; register contents shift out on the output.
// - Byte zero holds direction then address 6..0; byte one starts with address 7.
// - Seven bits after address bit 7 are ignored.
// - Write data starts at the third byte; any count of bytes may follow.
// - Register pointer advances by one after each data byte.
// - During reads, input bits after the header are ignored.
// - Header bytes always come from the master on the input line.
// - Rising chip select ends the transfer at any byte boundary.
// - Sample on rising clock, change on falling, MSB first, clock idles low.
// - After reset, address-select-zero pin level picks the interface; floating picks SPI.
// - Chosen interface stays fixed until the next reset.
// - On reset completion pulse interrupt high, low, high; if low, only raise.
// - Active bit clear: standby, access served, analog and sampling clocks stopped.
// - Active bit set: all blocks run and access is still served.
// - Active-to-standby keeps registers; standby-to-active reloads a chosen subset.
// - Sleep and wake are sub-states of active, not separate modes.
module ssp_top
  import ssp_pkg::*;
#(
  parameter int DETECT_LEN = ssp_pkg::DETECT_CYCLES
) (
  input  wire logic CLK,
  input  wire logic SRST,
  input  wire logic SCLK,
  input  wire logic CS_N,
  input  wire logic MOSI,
  output      logic MISO_O,
  output      logic MISO_OE_N,
  input  wire logic ADDR_SEL_ZERO_HIGH,
  input  wire logic ADDR_SEL_ZERO_LOW,
  input  wire logic INT_EVENT_LEVEL,
  output      logic INTERRUPT_OUT_FIRST,
  input  wire logic SLEEP_COND,
  output      logic SPI_SELECTED,
  output      logic ACTIVE,
  output      logic ANALOG_EN,
  output      logic SAMPLE_CLK_EN,
  output      logic SLEEP_SUBSTATE
);
  import ssp_pkg::*;

  // ---------------- SCLK domain ----------------
  logic [2:0]        bit_cnt;
  logic [1:0]        byte_idx;
  logic              is_write;
  logic              wr_tgl;
  logic              rd_tgl;
  logic [7:0]        shift_in;
  logic [6:0]        addr_lo;
  logic [REG_AW-1:0] ptr;
  logic [REG_AW-1:0] spi_wr_addr;
  logic [REG_DW-1:0] spi_wr_data;
  logic [REG_AW-1:0] spi_rd_addr;
  logic [REG_DW-1:0] out_sh;

  // ---------------- CLK domain ----------------
  logic [SYNC_W-1:0]       sync_q;
  logic                    wr_seen;
  logic                    rd_seen;
  logic                    cs_hist;
  logic                    wr_evt;
  logic                    rd_evt;
  logic                    wr_pend;
  logic                    rd_pend;
  logic                    serve_wr;
  logic                    serve_rd;
  logic                    rd_valid;
  logic [REG_DW-1:0]       rd_data;
  logic                    mem_we;
  logic [REG_AW-1:0]       mem_addr;
  logic [REG_DW-1:0]       mem_wdata;
  logic [REG_DW-1:0]       mem_rdata;
  logic                    reinit_busy;
  logic [REINIT_W-1:0]     reinit_idx;
  logic                    active_q;
  ssp_state_t              state;
  logic [DETECT_CNT_W-1:0] det_cnt;
  logic [INT_CNT_W-1:0]    int_cnt;
  logic                    int_was_low;
  logic                    spi_sel;
  logic                    link_ok;

  // Bit and byte framing; chip select high clears bit count, byte index and direction at once
  always_ff @(posedge SCLK or posedge CS_N) begin
    if (CS_N) begin
      bit_cnt  <= 3'h0;
      byte_idx <= 2'h0;
      is_write <= 1'b0;
    end else begin
      bit_cnt <= bit_cnt + 3'h1;
      if (bit_cnt == 3'h7 && byte_idx != 2'h2) begin
        byte_idx <= byte_idx + 2'h1;
      end
      if (byte_idx == 2'h0 && bit_cnt == 3'h0) begin
        is_write <= MOSI;
      end
    end
  end

  // Request toggles; reset with the frame so that idle is always zero
  always_ff @(posedge SCLK or posedge CS_N) begin
    if (CS_N) begin
      wr_tgl <= 1'b0;
      rd_tgl <= 1'b0;
    end else begin
      // Read of header address, then prefetch of the next byte per data byte
      if (!is_write && bit_cnt == 3'h0 && byte_idx != 2'h0) begin
        rd_tgl <= ~rd_tgl;
      end
      if (is_write && byte_idx == 2'h2 && bit_cnt == 3'h7) begin
        wr_tgl <= ~wr_tgl;
      end
    end
  end

  // Data path; held steady between requests so CLK side can sample it
  always_ff @(posedge SCLK) begin
    shift_in <= {shift_in[6:0], MOSI};
    if (byte_idx == 2'h0 && bit_cnt == 3'h7) begin
      addr_lo <= {shift_in[5:0], MOSI};
    end
    if (byte_idx == 2'h1 && bit_cnt == 3'h0) begin
      // Remaining bits of this byte are don't-care
      ptr <= {MOSI, addr_lo};
      if (!is_write) begin
        spi_rd_addr <= {MOSI, addr_lo};
      end
    end
    if (byte_idx == 2'h2 && bit_cnt == 3'h0 && !is_write) begin
      // Input bits in this phase are not looked at
      ptr         <= ptr + 8'h01;
      spi_rd_addr <= ptr + 8'h01;
    end
    if (byte_idx == 2'h2 && bit_cnt == 3'h7 && is_write) begin
      spi_wr_addr <= ptr;
      spi_wr_data <= {shift_in[6:0], MOSI};
      ptr         <= ptr + 8'h01;
    end
  end

  // Output shifter changes on the falling edge, MSB first
  always_ff @(negedge SCLK or posedge CS_N) begin
    if (CS_N) begin
      out_sh <= 8'h00;
    end else if (!is_write && byte_idx == 2'h2 && bit_cnt == 3'h0) begin
      // Fetched a full SCLK cycle or more earlier, so stable here
      out_sh <= rd_data;
    end else begin
      out_sh <= {out_sh[6:0], 1'b0};
    end
  end

  // Never tri-stated once SPI is chosen and the run state is reached; caller must keep bus point to point
  assign MISO_O = out_sh[7];

  // ---------------- Crossing into CLK ----------------
  ssp_sync #(
    .WIDTH     (SYNC_W),
    .RESET_VAL (SYNC_RESET)
  ) u_sync (
    .clk      (CLK),
    .srst     (SRST),
    .async_in ({ADDR_SEL_ZERO_LOW, ADDR_SEL_ZERO_HIGH, rd_tgl, wr_tgl, CS_N}),
    .sync_out (sync_q)
  );

  // Toggles drop to zero as the frame ends; mask the edges around that
  always_ff @(posedge CLK) begin
    if (SRST) begin
      wr_seen <= 1'b0;
      rd_seen <= 1'b0;
      cs_hist <= 1'b1;
    end else begin
      wr_seen <= sync_q[LANE_WR];
      rd_seen <= sync_q[LANE_RD];
      cs_hist <= sync_q[LANE_CS];
    end
  end

  assign link_ok = spi_sel && (state == ST_RUN) && !sync_q[LANE_CS] && !cs_hist;
  assign wr_evt  = link_ok && (sync_q[LANE_WR] != wr_seen);
  assign rd_evt  = link_ok && (sync_q[LANE_RD] != rd_seen);

  // Pending flags: a new event wins over the clear in the same cycle
  always_ff @(posedge CLK) begin
    if (SRST) begin
      wr_pend <= 1'b0;
      rd_pend <= 1'b0;
    end else begin
      wr_pend <= wr_evt | (wr_pend & ~serve_wr);
      rd_pend <= rd_evt | (rd_pend & ~serve_rd);
    end
  end

  // One storage port: reload first, then writes, then reads
  always_comb begin
    mem_we    = 1'b0;
    mem_addr  = spi_rd_addr;
    mem_wdata = 8'h00;
    serve_wr  = 1'b0;
    serve_rd  = 1'b0;
    if (reinit_busy) begin
      mem_we    = 1'b1;
      mem_addr  = REINIT_ADDR[reinit_idx];
      mem_wdata = REINIT_VAL[reinit_idx];
    end else if (wr_pend) begin
      mem_we    = 1'b1;
      mem_addr  = spi_wr_addr;
      mem_wdata = spi_wr_data;
      serve_wr  = 1'b1;
    end else if (rd_pend) begin
      serve_rd  = 1'b1;
    end
  end

  ssp_regmem u_regmem (
    .clk   (CLK),
    .we    (mem_we),
    .addr  (mem_addr),
    .wdata (mem_wdata),
    .rdata (mem_rdata)
  );

  // Read data handed back to SCLK side as a held word
  always_ff @(posedge CLK) begin
    if (SRST) begin
      rd_valid <= 1'b0;
      rd_data  <= 8'h00;
    end else begin
      rd_valid <= serve_rd;
      if (rd_valid) begin
        rd_data <= mem_rdata;
      end
    end
  end

  // Active bit mirrors the control register; storage is served in both modes
  always_ff @(posedge CLK) begin
    if (SRST) begin
      ACTIVE <= 1'b0;
    end else if (serve_wr && spi_wr_addr == CTRL_ADDR) begin
      ACTIVE <= spi_wr_data[ACTIVE_BIT];
    end
  end

  // Reload a subset on entering active; leaving active touches nothing
  always_ff @(posedge CLK) begin
    if (SRST) begin
      active_q    <= 1'b0;
      reinit_busy <= 1'b0;
      reinit_idx  <= '0;
    end else begin
      active_q <= ACTIVE;
      if (ACTIVE && !active_q) begin
        reinit_busy <= 1'b1;
        reinit_idx  <= '0;
      end else if (reinit_busy) begin
        reinit_idx <= reinit_idx + 2'h1;
        if (reinit_idx == REINIT_W'(REINIT_N - 1)) begin
          reinit_busy <= 1'b0;
        end
      end
    end
  end

  // Analog side and sampling clocks only while active; sleep is a sub-state
  always_ff @(posedge CLK) begin
    if (SRST) begin
      ANALOG_EN      <= 1'b0;
      SAMPLE_CLK_EN  <= 1'b0;
      SLEEP_SUBSTATE <= 1'b0;
    end else begin
      ANALOG_EN      <= ACTIVE;
      SAMPLE_CLK_EN  <= ACTIVE;
      SLEEP_SUBSTATE <= ACTIVE & SLEEP_COND;
    end
  end

  // ---------------- Detection and reset-complete pulse ----------------
  // Prior line level caught while reset is held, never by the reset itself
  always_ff @(posedge CLK) begin
    if (SRST) begin
      int_was_low <= ~INT_EVENT_LEVEL;
    end
  end

  always_ff @(posedge CLK) begin
    if (SRST) begin
      state   <= ST_DETECT;
      det_cnt <= '0;
      int_cnt <= '0;
      spi_sel <= 1'b0;
    end else begin
      unique case (state)
        ST_DETECT: begin
          det_cnt <= det_cnt + 20'h00001;
          if (det_cnt == DETECT_CNT_W'(DETECT_LEN - 1)) begin
            // Neither comparator tripped means the pin floats
            spi_sel <= ~sync_q[LANE_SA_HI] & ~sync_q[LANE_SA_LO];
            state   <= int_was_low ? ST_RUN : ST_INT_LOW;
          end
        end
        ST_INT_LOW: begin
          int_cnt <= int_cnt + 8'h01;
          if (int_cnt == INT_CNT_W'(INT_LOW_CYCLES - 1)) begin
            state <= ST_RUN;
          end
        end
        ST_RUN: begin
          // Marks the one-cycle rise as spent when the pin started low
          if (int_cnt == 8'h00) begin
            int_cnt <= 8'h01;
          end
          state <= ST_RUN;
        end
      endcase
    end
  end

  // Pin held released through detection so the float can be seen
  always_ff @(posedge CLK) begin
    if (SRST) begin
      MISO_OE_N <= 1'b1;
    end else begin
      MISO_OE_N <= ~(spi_sel && state == ST_RUN);
    end
  end

  // Prior level before the pulse, low for the pulse (one cycle high if it started low), then event logic owns it
  always_ff @(posedge CLK) begin
    if (SRST) begin
      INTERRUPT_OUT_FIRST <= 1'b1;
    end else begin
      unique case (state)
        ST_DETECT:  INTERRUPT_OUT_FIRST <= ~int_was_low;
        ST_INT_LOW: INTERRUPT_OUT_FIRST <= 1'b0;
        ST_RUN:     INTERRUPT_OUT_FIRST <= (int_cnt == 8'h00 && int_was_low) ? 1'b1
                                           : INT_EVENT_LEVEL;
      endcase
    end
  end

  assign SPI_SELECTED = spi_sel;

endmodule : ssp_top

// file: bench/ssp_top_props.sv
// Purpose: Concurrent checks on the serial register port top.
// Assumes: Comparator inputs are held steady from reset to detection end.
// Notes:   All checks sit in the CLK domain.
module ssp_top_props
  import ssp_pkg::*;
#(
  parameter int DETECT_LEN = ssp_pkg::DETECT_CYCLES
) (
  input wire logic CLK,
  input wire logic SRST,
  input wire logic SCLK,
  input wire logic CS_N,
  input wire logic MOSI,
  input wire logic MISO_O,
  input wire logic MISO_OE_N,
  input wire logic ADDR_SEL_ZERO_HIGH,
  input wire logic ADDR_SEL_ZERO_LOW,
  input wire logic INT_EVENT_LEVEL,
  input wire logic INTERRUPT_OUT_FIRST,
  input wire logic SLEEP_COND,
  input wire logic SPI_SELECTED,
  input wire logic ACTIVE,
  input wire logic ANALOG_EN,
  input wire logic SAMPLE_CLK_EN,
  input wire logic SLEEP_SUBSTATE
);
  timeunit 1ns;
  timeprecision 100ps;

  int unsigned since;
  logic [7:0]  low_run;
  logic        lvl_rst;

  default clocking @(posedge CLK); endclocking
  default disable iff (SRST);

  always_ff @(posedge CLK) begin
    if (SRST) since <= 0;
    else if (since < 100000) since <= since + 1;
  end

  // Saturates so a long low level cannot wrap into a false match
  always_ff @(posedge CLK) begin
    if (INTERRUPT_OUT_FIRST) low_run <= 8'h00;
    else if (low_run != 8'hFF) low_run <= low_run + 8'h01;
  end

  always_ff @(posedge CLK) begin
    if (SRST) lvl_rst <= INT_EVENT_LEVEL;
  end

  a_reset_vals: assert property ($past(SRST) |-> MISO_OE_N && !ACTIVE && !SPI_SELECTED)
    else $error("outputs not at reset values");
  a_oe_unsel: assert property (!SPI_SELECTED |-> MISO_OE_N)
    else $error("output driven while port not selected");
  a_oe_keep: assert property (!MISO_OE_N |=> !MISO_OE_N)
    else $error("serial output released");
  a_sel_pick: assert property (since == DETECT_LEN + 4 |->
      SPI_SELECTED == (!ADDR_SEL_ZERO_HIGH && !ADDR_SEL_ZERO_LOW))
    else $error("wrong interface chosen");
  a_sel_fixed: assert property (since > DETECT_LEN + 4 |-> $stable(SPI_SELECTED))
    else $error("interface choice changed");
  a_int_pulse: assert property ($rose(INTERRUPT_OUT_FIRST) && lvl_rst &&
      since < DETECT_LEN + 80 |-> low_run == INT_LOW_CYCLES)
    else $error("reset pulse low time wrong");
  a_analog_follow: assert property (ANALOG_EN == $past(ACTIVE))
    else $error("analog enable does not follow active bit");
  a_clk_gate: assert property (SAMPLE_CLK_EN == ANALOG_EN)
    else $error("sampling clock enable differs from analog enable");
  a_sleep_sub: assert property (SLEEP_SUBSTATE == ($past(ACTIVE) && $past(SLEEP_COND)))
    else $error("sleep substate outside active mode");
endmodule : ssp_top_props

bind ssp_top ssp_top_props #(.DETECT_LEN(DETECT_LEN)) i_ssp_top_props (
  .CLK(CLK), .SRST(SRST), .SCLK(SCLK), .CS_N(CS_N), .MOSI(MOSI),
  .MISO_O(MISO_O), .MISO_OE_N(MISO_OE_N), .ADDR_SEL_ZERO_HIGH(ADDR_SEL_ZERO_HIGH),
  .ADDR_SEL_ZERO_LOW(ADDR_SEL_ZERO_LOW), .INT_EVENT_LEVEL(INT_EVENT_LEVEL),
  .INTERRUPT_OUT_FIRST(INTERRUPT_OUT_FIRST), .SLEEP_COND(SLEEP_COND),
  .SPI_SELECTED(SPI_SELECTED), .ACTIVE(ACTIVE), .ANALOG_EN(ANALOG_EN),
  .SAMPLE_CLK_EN(SAMPLE_CLK_EN), .SLEEP_SUBSTATE(SLEEP_SUBSTATE));

// file: bench/ssp_master.sv
// Purpose: Behavioural single master for the serial register port.
// Assumes: Mode 0 at an 80 ns serial clock period.
// Notes:   Clock stands low between frames; data line is not held.
//          Frame start slides against CLK so the link phase is unrelated.
module ssp_master (
  output logic      sclk,
  output logic      cs_n,
  output logic      mosi,
  input  wire logic miso
);
  timeunit 1ns;
  timeprecision 100ps;

  logic [7:0] dat [8];
  logic [7:0] rd  [8];
  real        skew = 0.0;

  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    mosi = 1'b0;
  end

  task automatic send(input logic [7:0] b, output logic [7:0] r);
    for (int i = 7; i >= 0; i--) begin
      mosi = b[i];
      #40;
      sclk = 1'b1;
      r[i] = miso;
      #40;
      sclk = 1'b0;
    end
  endtask : send

  task automatic xfer(input logic wr, input logic [7:0] a, input int n);
    logic [7:0] r;
    cs_n = 1'b0;
    #(100.0 + skew);
    skew = (skew >= 3.0) ? 0.0 : skew + 0.7;
    send({wr, a[6:0]}, r);
    // Filler bits after address bit 7 are junk on purpose
    send({a[7], 7'h55}, r);
    for (int k = 0; k < n; k++) begin
      send(wr ? dat[k] : 8'hA5, r);
      rd[k] = r;
    end
    #100;
    cs_n = 1'b1;
    mosi = ~mosi;
    #300;
  endtask : xfer
endmodule : ssp_master

// file: bench/tb.sv
// Purpose: Self-checking bench for the serial register port.
// Assumes: Short detection window; master model drives the link.
// Notes:   Shared pin is never driven by the bench during detection.
module tb;
  import ssp_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;

  localparam int DL = 20;

  logic CLK = 1'b0;
  logic SRST = 1'b1;
  logic SCLK, CS_N, MOSI, MISO_O, MISO_OE_N;
  logic SEL_HI = 1'b0;
  logic SEL_LO = 1'b0;
  logic INT_LVL = 1'b1;
  logic INT_OUT, SLEEP_COND, SPI_SEL, ACTIVE, ANALOG_EN, SCLK_EN, SLEEP_SUB;
  int   fails = 0;
  int   checks = 0;

  always #2 CLK = ~CLK;

  ssp_master i_ssp_master (.sclk(SCLK), .cs_n(CS_N), .mosi(MOSI), .miso(MISO_O));

  ssp_top #(.DETECT_LEN(DL)) i_ssp_top (
    .CLK(CLK), .SRST(SRST), .SCLK(SCLK), .CS_N(CS_N), .MOSI(MOSI),
    .MISO_O(MISO_O), .MISO_OE_N(MISO_OE_N), .ADDR_SEL_ZERO_HIGH(SEL_HI),
    .ADDR_SEL_ZERO_LOW(SEL_LO), .INT_EVENT_LEVEL(INT_LVL),
    .INTERRUPT_OUT_FIRST(INT_OUT), .SLEEP_COND(SLEEP_COND),
    .SPI_SELECTED(SPI_SEL), .ACTIVE(ACTIVE), .ANALOG_EN(ANALOG_EN),
    .SAMPLE_CLK_EN(SCLK_EN), .SLEEP_SUBSTATE(SLEEP_SUB));

  task automatic stop_test;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : stop_test

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge CLK);
    #1;
  endtask : tick

  task automatic wr1(input logic [7:0] a, input logic [7:0] d);
    i_ssp_master.dat[0] = d;
    i_ssp_master.xfer(1'b1, a, 1);
    tick(1);
  endtask : wr1

  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    i_ssp_master.xfer(1'b0, a, 1);
    tick(1);
    chk(i_ssp_master.rd[0], e, "read data");
  endtask : rdc

  // Pin low count covers the whole window after release
  // Either start level must end in exactly one rise of the pin
  task automatic do_reset(input logic hi, input logic lo, input logic lvl);
    int   low;
    int   rises;
    logic last;
    low     = 0;
    rises   = 0;
    SEL_HI  = hi;
    SEL_LO  = lo;
    INT_LVL = lvl;
    SRST    = 1'b1;
    tick(10);
    last = INT_OUT;
    SRST = 1'b0;
    repeat (200) begin
      tick(1);
      if (INT_OUT === 1'b0) low++;
      if (INT_OUT === 1'b1 && last === 1'b0) rises++;
      last = INT_OUT;
    end
    if (lvl) chk(8'(low), 8'(INT_LOW_CYCLES), "reset pulse");
    chk(8'(rises), 8'h01, "reset pulse rise");
    chk(SPI_SEL, !(hi || lo), "selection");
    chk(MISO_OE_N, hi || lo, "output enable");
  endtask : do_reset

  task automatic t_detect;
    do_reset(1'b1, 1'b0, 1'b1);
    do_reset(1'b0, 1'b1, 1'b0);
    do_reset(1'b0, 1'b0, 1'b1);
    $display("test detect done");
  endtask : t_detect

  task automatic t_burst;
    logic [7:0] e [3];
    e = '{8'h11, 8'h22, 8'h33};
    for (int k = 0; k < 3; k++) i_ssp_master.dat[k] = e[k];
    i_ssp_master.xfer(1'b1, 8'hFE, 3);
    i_ssp_master.xfer(1'b0, 8'hFE, 3);
    for (int k = 0; k < 3; k++) chk(i_ssp_master.rd[k], e[k], "burst");
    rdc(8'h00, 8'h33);
    $display("test burst done");
  endtask : t_burst

  task automatic t_mode;
    wr1(8'h0C, 8'h05);
    rdc(8'h0C, 8'h05);
    chk(ANALOG_EN, 1'b0, "standby analog");
    wr1(CTRL_ADDR, 8'h01);
    chk(ACTIVE, 1'b1, "active");
    chk(ANALOG_EN, 1'b1, "analog on");
    chk(SCLK_EN, 1'b1, "sampling clock on");
    rdc(8'h0C, 8'h00);
    SLEEP_COND = 1'b1;
    tick(3);
    chk(SLEEP_SUB, 1'b1, "sleep substate");
    chk(ACTIVE, 1'b1, "still active");
    SLEEP_COND = 1'b0;
    wr1(8'h0C, 8'h07);
    wr1(CTRL_ADDR, 8'h00);
    chk(ACTIVE, 1'b0, "standby");
    chk(SCLK_EN, 1'b0, "sampling clock off");
    rdc(8'h0C, 8'h07);
    $display("test mode done");
  endtask : t_mode

  initial begin
    SLEEP_COND = 1'b0;
    tick(1);
    t_detect();
    t_burst();
    t_mode();
    stop_test();
  end

  initial begin
    #200000;
    fails++;
    $display("ERROR %0t run did not finish", $time);
    stop_test();
  end
endmodule : tb
